// ==== ipw_top.sv ====
/*
 * Interrupt priority and standby-wake block: merges source flags onto vectors,
 * tracks nesting, presents the winner to the core, runs halt/hold/crystal hold.
 * Assumes source flags come from logic on i_sys_clk and are cleared at source;
 * the reset pin is asynchronous to the clock and is synchronised here.
 */
`timescale 1ns/1ps
`include "ipw_params.svh"

module ipw_top #(
    parameter int NUM_SRC = `IPW_NUM_SRC,
    parameter int NUM_VEC = `IPW_NUM_VEC
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // System reset causes
    input wire logic i_reset_pin_n,
    input wire logic i_wdt_reset,
    // Interrupt sources
    input wire logic [NUM_SRC-1:0] i_src_flag,
    input wire logic [NUM_SRC-1:0] i_src_enable,
    input wire logic [NUM_VEC-1:0] i_vec_level_sel,
    // Core interrupt handshake
    input wire logic i_irq_ack,
    input wire logic i_irq_return,
    output logic o_irq_req,
    output logic [`IPW_ADDR_W-1:0] o_irq_vector,
    output ipw_pkg::ipw_level_t o_irq_level,
    output logic [2:0] o_in_service,
    // Standby requests from the core
    input wire logic i_halt_req,
    input wire logic i_hold_req,
    input wire logic i_xtal_hold_req,
    // Standby and clock controls
    output ipw_pkg::ipw_mode_t o_mode,
    output logic o_sys_reset,
    output logic o_cpu_stop,
    output logic o_periph_stop,
    output logic o_base_timer_stop,
    output logic o_pll_stop,
    output logic o_ceramic_oscillator_stop,
    output logic o_rc_osc_stop,
    output logic o_xtal_osc_stop
);

    // Source map and vector table are fixed in size
    if (NUM_SRC != `IPW_NUM_SRC || NUM_VEC != `IPW_NUM_VEC)
    begin
        $error("source map is fixed at its documented size");
    end

    typedef struct packed {
        logic [1:0] res_sync;
        ipw_pkg::ipw_mode_t mode;
        logic [2:0] in_svc;
        logic irq_req;
        logic [`IPW_VEC_W-1:0] irq_vec;
        ipw_pkg::ipw_level_t irq_level;
        logic sys_reset;
        logic cpu_stop;
        logic periph_stop;
        logic bt_stop;
        logic pll_stop;
        logic cf_stop;
        logic rc_stop;
        logic xtal_stop;
    } ipw_state_t;

    ipw_state_t state_r;
    ipw_state_t state_nxt;
    logic [NUM_VEC-1:0] vec_pend;
    logic [NUM_SRC-1:0] src_act;
    logic hold_wake;
    logic xhold_wake;
    logic sys_rst_evt;

    ipw_arb_if arb_bus ();

    ipw_arbiter u_arbiter (
        .bus(arb_bus)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Vector that a source index belongs to
    function automatic logic [`IPW_VEC_W-1:0] src_vector(input logic [5:0] s);
        if (s >= `IPW_BASE_V9)
            return 4'h9;
        else if (s >= `IPW_BASE_V8)
            return 4'h8;
        else if (s >= `IPW_BASE_V7)
            return 4'h7;
        else if (s >= `IPW_BASE_V6)
            return 4'h6;
        else if (s >= `IPW_BASE_V5)
            return 4'h5;
        else if (s >= `IPW_BASE_V4)
            return 4'h4;
        else if (s >= `IPW_BASE_V3)
            return 4'h3;
        else if (s >= `IPW_BASE_V2)
            return 4'h2;
        else if (s >= `IPW_BASE_V1)
            return 4'h1;
        else
            return 4'h0;
    endfunction

    // Level now in service, from the nesting mask
    function automatic ipw_pkg::ipw_level_t svc_level(input logic [2:0] m);
        if (m[`IPW_SVC_TOP])
            return ipw_pkg::IPW_LVL_TOP;
        else if (m[`IPW_SVC_HIGH])
            return ipw_pkg::IPW_LVL_HIGH;
        else if (m[`IPW_SVC_LOW])
            return ipw_pkg::IPW_LVL_LOW;
        else
            return ipw_pkg::IPW_LVL_NONE;
    endfunction

    // Mask bit of a level
    function automatic logic [2:0] level_bit(input ipw_pkg::ipw_level_t l);
        unique case (l)
            ipw_pkg::IPW_LVL_TOP: return 3'h4;
            ipw_pkg::IPW_LVL_HIGH: return 3'h2;
            ipw_pkg::IPW_LVL_LOW: return 3'h1;
            ipw_pkg::IPW_LVL_NONE: return 3'h0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Source merge and wake decode

    always_comb
    begin
        src_act = i_src_flag & i_src_enable;
        vec_pend = '0;
        // Flags stay pending here until the source itself clears them
        for (int s = 0; s < NUM_SRC; s++)
        begin
            if (src_act[s])
                vec_pend[src_vector(6'(s))] = 1'b1;
        end
        hold_wake = src_act[`IPW_SRC_PIN_A] | src_act[`IPW_SRC_PIN_B]
            | src_act[`IPW_SRC_PIN_C] | src_act[`IPW_SRC_PIN_E]
            | src_act[`IPW_SRC_PIN_F] | src_act[`IPW_SRC_PORT0]
            | src_act[`IPW_SRC_BUS_ACTIVE];
        xhold_wake = hold_wake | src_act[`IPW_SRC_BASE_TIMER]
            | src_act[`IPW_SRC_INFRARED];
        sys_rst_evt = ~state_r.res_sync[1] | i_wdt_reset;
    end

    assign arb_bus.pend = vec_pend;
    assign arb_bus.lvl_sel = i_vec_level_sel;
    assign arb_bus.cur_level = svc_level(state_r.in_svc);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        logic [2:0] svc;
        logic [2:0] top_bit;
        svc = state_r.in_svc;
        top_bit = level_bit(svc_level(state_r.in_svc));
        state_nxt = state_r;
        state_nxt.res_sync = {state_r.res_sync[0], i_reset_pin_n};
        state_nxt.sys_reset = sys_rst_evt;

        // Return from service drops the innermost level
        if (i_irq_return)
            svc = svc & ~top_bit;
        if (i_irq_ack && state_r.irq_req)
            svc = svc | level_bit(state_r.irq_level);
        state_nxt.in_svc = svc;

        unique case (state_r.mode)
            ipw_pkg::IPW_MODE_RUN:
            begin
                if (i_xtal_hold_req)
                    state_nxt.mode = ipw_pkg::IPW_MODE_XHOLD;
                else if (i_hold_req)
                    state_nxt.mode = ipw_pkg::IPW_MODE_HOLD;
                else if (i_halt_req)
                    state_nxt.mode = ipw_pkg::IPW_MODE_HALT;
            end
            ipw_pkg::IPW_MODE_HALT:
            begin
                if (|src_act)
                    state_nxt.mode = ipw_pkg::IPW_MODE_RUN;
            end
            ipw_pkg::IPW_MODE_HOLD:
            begin
                if (hold_wake)
                    state_nxt.mode = ipw_pkg::IPW_MODE_RUN;
            end
            ipw_pkg::IPW_MODE_XHOLD:
            begin
                if (xhold_wake)
                    state_nxt.mode = ipw_pkg::IPW_MODE_RUN;
            end
            default:
                state_nxt.mode = ipw_pkg::IPW_MODE_RUN;
        endcase

        // Reset pin or watchdog ends any standby and clears nesting
        if (sys_rst_evt)
        begin
            state_nxt.mode = ipw_pkg::IPW_MODE_RUN;
            state_nxt.in_svc = 3'h0;
        end

        // Offer only while running; drop for a cycle after each ack
        if (state_nxt.mode == ipw_pkg::IPW_MODE_RUN && !sys_rst_evt
            && !(i_irq_ack && state_r.irq_req) && !i_irq_return)
        begin
            state_nxt.irq_req = arb_bus.gnt_valid;
            state_nxt.irq_vec = arb_bus.gnt_vec;
            state_nxt.irq_level = arb_bus.gnt_level;
        end
        else
        begin
            state_nxt.irq_req = 1'b0;
        end

        // Clock and stop controls follow the mode being entered
        unique case (state_nxt.mode)
            ipw_pkg::IPW_MODE_HALT:
            begin
                state_nxt.cpu_stop = 1'b1;
                state_nxt.periph_stop = 1'b0;
                state_nxt.bt_stop = 1'b0;
                state_nxt.pll_stop = state_r.pll_stop;
                state_nxt.cf_stop = state_r.cf_stop;
                state_nxt.rc_stop = state_r.rc_stop;
                state_nxt.xtal_stop = state_r.xtal_stop;
            end
            ipw_pkg::IPW_MODE_HOLD:
            begin
                state_nxt.cpu_stop = 1'b1;
                state_nxt.periph_stop = 1'b1;
                state_nxt.bt_stop = 1'b1;
                state_nxt.pll_stop = 1'b1;
                state_nxt.cf_stop = 1'b1;
                state_nxt.rc_stop = 1'b1;
                state_nxt.xtal_stop = 1'b1;
            end
            ipw_pkg::IPW_MODE_XHOLD:
            begin
                state_nxt.cpu_stop = 1'b1;
                state_nxt.periph_stop = 1'b1;
                state_nxt.bt_stop = 1'b0;
                state_nxt.pll_stop = 1'b1;
                state_nxt.cf_stop = 1'b1;
                state_nxt.rc_stop = 1'b1;
                state_nxt.xtal_stop = state_r.xtal_stop;
            end
            default:
            begin
                state_nxt.cpu_stop = 1'b0;
                state_nxt.periph_stop = 1'b0;
                state_nxt.bt_stop = 1'b0;
                state_nxt.pll_stop = 1'b0;
                state_nxt.cf_stop = 1'b0;
                state_nxt.rc_stop = 1'b0;
                state_nxt.xtal_stop = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_r <= '{
                res_sync: 2'h3,
                mode: ipw_pkg::IPW_MODE_RUN,
                in_svc: 3'h0,
                irq_req: 1'b0,
                irq_vec: '0,
                irq_level: ipw_pkg::IPW_LVL_NONE,
                sys_reset: 1'b0,
                cpu_stop: 1'b0,
                periph_stop: 1'b0,
                bt_stop: 1'b0,
                pll_stop: 1'b0,
                cf_stop: 1'b0,
                rc_stop: 1'b0,
                xtal_stop: 1'b0
            };
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_irq_req = state_r.irq_req;
    assign o_irq_vector = {`IPW_ADDR_HI_PAD, state_r.irq_vec, `IPW_ADDR_LOW_BITS};
    assign o_irq_level = state_r.irq_level;
    assign o_in_service = state_r.in_svc;
    assign o_mode = state_r.mode;
    assign o_sys_reset = state_r.sys_reset;
    assign o_cpu_stop = state_r.cpu_stop;
    assign o_periph_stop = state_r.periph_stop;
    assign o_base_timer_stop = state_r.bt_stop;
    assign o_pll_stop = state_r.pll_stop;
    assign o_ceramic_oscillator_stop = state_r.cf_stop;
    assign o_rc_osc_stop = state_r.rc_stop;
    assign o_xtal_osc_stop = state_r.xtal_stop;

endmodule

// ==== ipw_params.svh ====
/*
 * Constants of the interrupt priority and standby-wake block: source map,
 * vector addresses and wake-source positions.
 * Assumes inclusion by the package and the block modules by bare name.
 */

`ifndef IPW_PARAMS_SVH
`define IPW_PARAMS_SVH

`define IPW_NUM_SRC 41
`define IPW_NUM_VEC 10
`define IPW_VEC_W 4
`define IPW_ADDR_W 17
`define IPW_ADDR_HI_PAD 10'h000
`define IPW_ADDR_LOW_BITS 3'h3

// First source index of each vector 1..9 (vector 0 starts at 0)
`define IPW_BASE_V1 6'h01
`define IPW_BASE_V2 6'h02
`define IPW_BASE_V3 6'h07
`define IPW_BASE_V4 6'h0a
`define IPW_BASE_V5 6'h0f
`define IPW_BASE_V6 6'h14
`define IPW_BASE_V7 6'h16
`define IPW_BASE_V8 6'h1a
`define IPW_BASE_V9 6'h21

// Vectors that may take the highest level
`define IPW_VEC_PIN_A 4'h0
`define IPW_VEC_PIN_B 4'h1

// Wake-relevant source positions
`define IPW_SRC_PIN_A 0
`define IPW_SRC_PIN_B 1
`define IPW_SRC_PIN_C 2
`define IPW_SRC_PIN_E 4
`define IPW_SRC_BUS_ACTIVE 5
`define IPW_SRC_INFRARED 6
`define IPW_SRC_PIN_F 8
`define IPW_SRC_BASE_TIMER 9
`define IPW_SRC_PORT0 33

// In-service mask bit per level
`define IPW_SVC_LOW 0
`define IPW_SVC_HIGH 1
`define IPW_SVC_TOP 2

`endif

// ==== ipw_pkg.sv ====
/*
 * Types of the interrupt priority and standby-wake block.
 * Assumes ipw_params.svh is on the include path.
 */
`include "ipw_params.svh"

package ipw_pkg;

    // Ordered so that numeric compare gives rank
    typedef enum logic [1:0] {
        IPW_LVL_NONE = 2'h0,
        IPW_LVL_LOW = 2'h1,
        IPW_LVL_HIGH = 2'h2,
        IPW_LVL_TOP = 2'h3
    } ipw_level_t;

    typedef enum logic [3:0] {
        IPW_MODE_RUN = 4'h1,
        IPW_MODE_HALT = 4'h2,
        IPW_MODE_HOLD = 4'h4,
        IPW_MODE_XHOLD = 4'h8
    } ipw_mode_t;

endpackage

// ==== ipw_arb_if.sv ====
/*
 * Carrier between the block's control logic and its arbiter.
 * Assumes the package ipw_pkg is compiled first.
 */
`timescale 1ns/1ps
`include "ipw_params.svh"

interface ipw_arb_if;
    logic [`IPW_NUM_VEC-1:0] pend;
    logic [`IPW_NUM_VEC-1:0] lvl_sel;
    ipw_pkg::ipw_level_t cur_level;
    logic gnt_valid;
    logic [`IPW_VEC_W-1:0] gnt_vec;
    ipw_pkg::ipw_level_t gnt_level;

    modport arb (
        input pend,
        input lvl_sel,
        input cur_level,
        output gnt_valid,
        output gnt_vec,
        output gnt_level
    );

    modport ctl (
        output pend,
        output lvl_sel,
        output cur_level,
        input gnt_valid,
        input gnt_vec,
        input gnt_level
    );
endinterface

// ==== ipw_arbiter.sv ====
/*
 * Combinational vector arbiter: picks one pending vector by level and address.
 * Assumes the caller registers its result; holds no state of its own.
 */
`timescale 1ns/1ps
`include "ipw_params.svh"

module ipw_arbiter (
    ipw_arb_if.arb bus
);

    // Level a vector takes from its select bit
    function automatic ipw_pkg::ipw_level_t vec_level(
        input logic [`IPW_VEC_W-1:0] v,
        input logic sel
    );
        if (!sel)
            return ipw_pkg::IPW_LVL_LOW;
        else if (v == `IPW_VEC_PIN_A || v == `IPW_VEC_PIN_B)
            return ipw_pkg::IPW_LVL_TOP;
        else
            return ipw_pkg::IPW_LVL_HIGH;
    endfunction

    always_comb
    begin
        ipw_pkg::ipw_level_t lvl;
        lvl = ipw_pkg::IPW_LVL_NONE;
        bus.gnt_valid = 1'b0;
        bus.gnt_vec = '0;
        bus.gnt_level = ipw_pkg::IPW_LVL_NONE;
        // Walk downward so a tie leaves the smallest vector standing
        for (int v = `IPW_NUM_VEC - 1; v >= 0; v--)
        begin
            lvl = vec_level(`IPW_VEC_W'(v), bus.lvl_sel[v]);
            if (bus.pend[v] && lvl > bus.cur_level
                && lvl >= bus.gnt_level)
            begin
                bus.gnt_valid = 1'b1;
                bus.gnt_vec = `IPW_VEC_W'(v);
                bus.gnt_level = lvl;
            end
        end
    end

endmodule

// ==== ipw_top_sva.sv ====
/* Checker on the ports of ipw_top: offer level, vector form, standby stops and wakes.
   Assumes one clock domain; bound into ipw_top from the foot of this file. */
`timescale 1ns/1ps
`include "ipw_params.svh"

module ipw_top_sva #(
    parameter int NUM_SRC = 41,
    parameter int NUM_VEC = 10
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Watched inputs
    input wire logic i_wdt_reset,
    input wire logic [NUM_SRC-1:0] i_src_flag,
    input wire logic [NUM_SRC-1:0] i_src_enable,
    input wire logic [NUM_VEC-1:0] i_vec_level_sel,
    // Watched outputs
    input wire logic o_irq_req,
    input wire logic [`IPW_ADDR_W-1:0] o_irq_vector,
    input wire ipw_pkg::ipw_level_t o_irq_level,
    input wire logic [2:0] o_in_service,
    input wire ipw_pkg::ipw_mode_t o_mode,
    input wire logic o_sys_reset,
    input wire logic o_cpu_stop,
    input wire logic o_periph_stop,
    input wire logic o_base_timer_stop,
    input wire logic o_pll_stop,
    input wire logic o_ceramic_oscillator_stop,
    input wire logic o_rc_osc_stop,
    input wire logic o_xtal_osc_stop
);
    logic [NUM_SRC-1:0] act;
    logic [1:0] svc_lvl;
    logic [1:0] exp_lvl;
    logic [NUM_VEC-1:0] sel_q;
    logic [3:0] vec;
    logic [3:0] osc;
    logic hold_wake;
    logic m_run;
    logic m_halt;
    logic m_hold;
    logic m_xhold;

    assign act = i_src_flag & i_src_enable;
    assign svc_lvl = o_in_service[2] ? 2'h3 : o_in_service[1] ? 2'h2 : {1'b0, o_in_service[0]};
    assign vec = o_irq_vector[6:3];
    assign exp_lvl = !sel_q[vec] ? 2'h1 : (vec < 4'h2) ? 2'h3 : 2'h2;
    assign hold_wake = act[0] | act[1] | act[2] | act[4] | act[5] | act[8] | act[33];
    assign osc = {o_pll_stop, o_ceramic_oscillator_stop, o_rc_osc_stop, o_xtal_osc_stop};
    assign m_run = o_mode == ipw_pkg::IPW_MODE_RUN;
    assign m_halt = o_mode == ipw_pkg::IPW_MODE_HALT;
    assign m_hold = o_mode == ipw_pkg::IPW_MODE_HOLD;
    assign m_xhold = o_mode == ipw_pkg::IPW_MODE_XHOLD;

    // Level select as the arbiter saw it, one cycle before the offer
    always_ff @(posedge i_sys_clk)
        sel_q <= i_vec_level_sel;

    ////////////////////////////////////////
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);

    a_offer_above_svc: assert property (o_irq_req |-> o_irq_level > svc_lvl)
        else $error("offer not above service level");
    a_offer_level: assert property (o_irq_req |-> o_irq_level == exp_lvl)
        else $error("offer level wrong");
    a_vector_form: assert property (o_irq_req |-> o_irq_vector == {10'h000, vec, 3'h3}
        && vec < 4'ha) else $error("vector address malformed");
    a_halt_stops: assert property (m_halt |-> o_cpu_stop && !o_periph_stop
        && !o_base_timer_stop) else $error("halt stop outputs wrong");
    a_halt_osc_kept: assert property (m_halt && $past(m_run) |-> $stable(osc))
        else $error("halt changed oscillators");
    a_hold_stops: assert property (m_hold |-> o_cpu_stop && o_periph_stop
        && o_base_timer_stop && &osc) else $error("hold stop outputs wrong");
    a_xhold_stops: assert property (m_xhold |-> o_cpu_stop && o_periph_stop
        && !o_base_timer_stop && &osc[3:1]) else $error("crystal hold stops wrong");
    a_xhold_xtal: assert property (m_xhold && $past(m_run) |-> $stable(o_xtal_osc_stop))
        else $error("crystal hold changed crystal");
    a_halt_wake: assert property (m_halt && |act |=> m_run)
        else $error("halt not released");
    a_hold_wake: assert property (m_hold && hold_wake |=> m_run)
        else $error("hold not released");
    a_xhold_wake: assert property (m_xhold && (hold_wake || act[9] || act[6]) |=> m_run)
        else $error("crystal hold not released");
    a_wdt_release: assert property (i_wdt_reset |=> m_run && o_sys_reset && !o_irq_req
        && o_in_service == 3'h0) else $error("watchdog reset not applied");

    c_nested: cover property (o_in_service == 3'h6);
    c_hold_wake: cover property (m_run && $past(m_hold));
    c_xhold_wake: cover property (m_run && $past(m_xhold));
    c_wdt: cover property (i_wdt_reset && !m_run);
endmodule

bind ipw_top ipw_top_sva #(.NUM_SRC(NUM_SRC), .NUM_VEC(NUM_VEC)) u_sva (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_wdt_reset(i_wdt_reset),
    .i_src_flag(i_src_flag), .i_src_enable(i_src_enable), .i_vec_level_sel(i_vec_level_sel),
    .o_irq_req(o_irq_req), .o_irq_vector(o_irq_vector), .o_irq_level(o_irq_level),
    .o_in_service(o_in_service), .o_mode(o_mode), .o_sys_reset(o_sys_reset),
    .o_cpu_stop(o_cpu_stop), .o_periph_stop(o_periph_stop),
    .o_base_timer_stop(o_base_timer_stop), .o_pll_stop(o_pll_stop),
    .o_ceramic_oscillator_stop(o_ceramic_oscillator_stop), .o_rc_osc_stop(o_rc_osc_stop),
    .o_xtal_osc_stop(o_xtal_osc_stop)
);

// ==== ipw_core_model.sv ====
/* Processor core side of the handshake: takes a standing offer after a set wait.
   Assumes the bench changes enable and wait off the rising edge. */
`timescale 1ns/1ps

module ipw_core_model (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Bench control
    input wire logic i_ack_en,
    input wire logic [3:0] i_ack_wait,
    // Interrupt handshake
    input wire logic i_irq_req,
    output logic o_irq_ack
);
    logic [3:0] wait_r;

    // One-cycle ack, only while an offer stands
    always @(negedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset || o_irq_ack || !i_irq_req || !i_ack_en)
        begin
            wait_r <= 4'h0;
            o_irq_ack <= 1'b0;
        end
        else if (wait_r >= i_ack_wait)
            o_irq_ack <= 1'b1;
        else
            wait_r <= wait_r + 4'h1;
    end
endmodule

// ==== interrupt_priority_wake_test.sv ====
/* Self-checking bench of ipw_top with a core model taking offers.
   Assumes the checker is bound in from its own file. */
`timescale 1ns/1ps

module interrupt_priority_wake_test;
    localparam int BASE [10] = '{0, 1, 2, 7, 10, 15, 20, 22, 26, 33};
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_reset_pin_n = 1'b1;
    logic i_wdt_reset = 1'b0;
    logic [40:0] i_src_flag = '0;
    logic [40:0] i_src_enable = '1;
    logic [9:0] i_vec_level_sel = '0;
    logic i_irq_ack;
    logic i_irq_return = 1'b0;
    logic i_halt_req = 1'b0;
    logic i_hold_req = 1'b0;
    logic i_xtal_hold_req = 1'b0;
    logic ack_en = 1'b0;
    logic [3:0] ack_wait = 4'h0;
    logic o_irq_req;
    logic [16:0] o_irq_vector;
    ipw_pkg::ipw_level_t o_irq_level;
    logic [2:0] o_in_service;
    ipw_pkg::ipw_mode_t o_mode;
    logic o_sys_reset;
    logic [6:0] stops;
    int compares = 0;
    int fail_count = 0;

    always #5 i_sys_clk = ~i_sys_clk;

    ipw_top dut (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_reset_pin_n(i_reset_pin_n),
        .i_wdt_reset(i_wdt_reset), .i_src_flag(i_src_flag), .i_src_enable(i_src_enable),
        .i_vec_level_sel(i_vec_level_sel), .i_irq_ack(i_irq_ack), .i_irq_return(i_irq_return),
        .o_irq_req(o_irq_req), .o_irq_vector(o_irq_vector), .o_irq_level(o_irq_level),
        .o_in_service(o_in_service), .i_halt_req(i_halt_req), .i_hold_req(i_hold_req),
        .i_xtal_hold_req(i_xtal_hold_req), .o_mode(o_mode), .o_sys_reset(o_sys_reset),
        .o_cpu_stop(stops[6]), .o_periph_stop(stops[5]), .o_base_timer_stop(stops[4]),
        .o_pll_stop(stops[3]), .o_ceramic_oscillator_stop(stops[2]),
        .o_rc_osc_stop(stops[1]), .o_xtal_osc_stop(stops[0])
    );

    ipw_core_model core (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ack_en(ack_en),
        .i_ack_wait(ack_wait), .i_irq_req(o_irq_req), .o_irq_ack(i_irq_ack)
    );

    ////////////////////////////////////////
    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    task automatic wait_req(input logic exp);
        int n;
        n = 0;
        while (o_irq_req !== exp && n < 8)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        chk("irq_req", 17'(exp), 17'(o_irq_req));
    endtask

    task automatic wait_svc(input logic [2:0] exp);
        int n;
        n = 0;
        while (o_in_service !== exp && n < 12)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        chk("in_service", 17'(exp), 17'(o_in_service));
    endtask

    task automatic ret();
        i_irq_return = 1'b1;
        @(negedge i_sys_clk);
        i_irq_return = 1'b0;
    endtask

    task automatic sys_rst(input logic pin);
        int n;
        n = 0;
        i_reset_pin_n = !pin;
        i_wdt_reset = !pin;
        while (o_sys_reset !== 1'b1 && n < 6)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        chk("reset mode", 17'h1, 17'(o_mode));
        chk("in_service", 17'h0, 17'(o_in_service));
        chk("sys_reset", 17'h1, 17'(o_sys_reset));
        i_reset_pin_n = 1'b1;
        i_wdt_reset = 1'b0;
        while (o_sys_reset !== 1'b0 && n < 12)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        chk("sys_reset", 17'h0, 17'(o_sys_reset));
    endtask

    task automatic t_map();
        int v;
        for (int s = 0; s < 41; s++)
        begin
            v = 0;
            for (int k = 0; k < 10; k++)
                if (s >= BASE[k])
                    v = k;
            i_src_flag = 41'h1 << s;
            wait_req(1'b1);
            chk("vector", 17'(3 + 8 * v), o_irq_vector);
            i_src_flag = '0;
            wait_req(1'b0);
        end
    endtask

    task automatic t_prio();
        int a[5] = '{2, 2, 0, 1, 0};
        int b[5] = '{10, 10, 10, 40, 1};
        logic [9:0] sel[5] = '{10'h000, 10'h010, 10'h011, 10'h200, 10'h002};
        int ev[5] = '{2, 4, 0, 9, 1};
        int el[5] = '{1, 2, 3, 2, 3};
        for (int i = 0; i < 5; i++)
        begin
            i_vec_level_sel = sel[i];
            i_src_flag = (41'h1 << a[i]) | (41'h1 << b[i]);
            wait_req(1'b1);
            chk("vector", 17'(3 + 8 * ev[i]), o_irq_vector);
            chk("level", 17'(el[i]), 17'(o_irq_level));
            i_src_flag = '0;
            wait_req(1'b0);
        end
    endtask

    task automatic t_nest();
        ack_en = 1'b1;
        ack_wait = 4'h2;
        i_vec_level_sel = 10'h009;
        i_src_flag = 41'h84;
        wait_svc(3'h2);
        for (int k = 0; k < 4; k++)
        begin
            @(negedge i_sys_clk);
            chk("refused", 17'h0, 17'(o_irq_req));
        end
        i_src_flag[0] = 1'b1;
        wait_svc(3'h6);
        ack_en = 1'b0;
        i_src_flag[0] = 1'b0;
        ret();
        wait_svc(3'h2);
        ret();
        wait_svc(3'h0);
        wait_req(1'b1);
        chk("vector", 17'h1b, o_irq_vector);
        ack_en = 1'b1;
        wait_svc(3'h2);
        ack_en = 1'b0;
        sys_rst(1'b0);
        i_src_flag = '0;
        wait_req(1'b0);
    endtask

    task automatic t_standby();
        int kd[13] = '{0, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2, 1, 2};
        int sr[13] = '{20, 20, 0, 1, 2, 4, 8, 33, 5, 9, 6, 9, 20};
        logic wk[13] = '{1, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1, 0, 0};
        logic [6:0] stp[3] = '{7'h40, 7'h7f, 7'h6e};
        for (int i = 0; i < 13; i++)
        begin
            i_halt_req = (kd[i] == 0);
            i_hold_req = (kd[i] == 1);
            i_xtal_hold_req = (kd[i] == 2);
            @(negedge i_sys_clk);
            {i_halt_req, i_hold_req, i_xtal_hold_req} = 3'h0;
            chk("mode", 17'(4'h2 << kd[i]), 17'(o_mode));
            chk("stops", 17'(stp[kd[i]]), 17'(stops));
            i_src_flag = 41'h1 << sr[i];
            @(negedge i_sys_clk);
            chk("wake", wk[i] ? 17'h1 : 17'(4'h2 << kd[i]), 17'(o_mode));
            if (!wk[i])
                sys_rst(i % 2 == 0);
            i_src_flag = '0;
            wait_req(1'b0);
        end
    endtask

    task automatic final_report();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        fail_count++;
        final_report();
    end

    initial
    begin
        repeat (5) @(negedge i_sys_clk);
        i_reset = 1'b0;
        @(negedge i_sys_clk);
        t_map();
        t_prio();
        t_nest();
        t_standby();
        final_report();
    end
endmodule
